// [verilog/sleep_ctrl_consts.svh]
// Purpose: timing constants for the sram sleep control
// Assumes: 50 MHz system clock
// Notes:   cycle counts are sram clock cycles
`ifndef SLEEP_CTRL_CONSTS_SVH
`define SLEEP_CTRL_CONSTS_SVH
`define ENTRY_CYCLES        2'h2
`define WAKE_CYCLES         2'h2
`define CLK_PERIOD_NS       20
`define RECOVERY_NS         20
`define RECOVERY_CYCLES     (((`RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                             ((`RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`endif

// [verilog/sleep_ctrl_pkg.sv]
// Purpose: types for the sram sleep control
// Assumes: nothing
// Notes:   none
`default_nettype none
package sleep_ctrl_pkg;
    typedef enum logic [1:0] {ST_AWAKE, ST_ENTER, ST_ASLEEP, ST_WAKE} sleep_state_t;
    typedef struct packed {
        logic asleep;
        logic recovering;
        logic access_ok;
        logic outputs_off;
    } sleep_status_t;
endpackage
`default_nettype wire

// [verilog/sram_sleep_mode_control.sv]
// Purpose: sleep entry and wake sequencing of a synchronous burst sram
// Assumes: sleep_request meets setup and hold to sys_clk
// Notes:   gates accesses and data drivers; datapath is outside
`include "sleep_ctrl_consts.svh"
`default_nettype none
module sram_sleep_mode_control
    import sleep_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // sleep request from controller
    input  wire logic          sleep_request,
    // access request from the command decoder
    input  wire logic          cmd_access,
    input  wire logic          cmd_write,
    // gated access and data output enable (low means drive)
    output logic               access_en,
    output logic               write_en,
    output logic               dq_oe_n,
    output sleep_ctrl_pkg::sleep_status_t status
);
    import sleep_ctrl_pkg::*;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    sleep_state_t state_r, state_nxt;
    logic [1:0]   cnt_r, cnt_nxt;
    logic [1:0]   rec_r, rec_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        rec_nxt   = (rec_r != 2'h0) ? rec_r - 2'h1 : 2'h0;
        unique case (state_r)
            ST_AWAKE:
            begin
                if (sleep_request)
                begin
                    state_nxt = ST_ENTER;
                    cnt_nxt   = `ENTRY_CYCLES - 2'h1;
                end
            end
            ST_ENTER:
            begin
                // a request dropped here is not aborted: sleep is reached, then left
                if (cnt_r == 2'h1)
                    state_nxt = ST_ASLEEP;
                cnt_nxt = cnt_r - 2'h1;
            end
            ST_ASLEEP:
            begin
                // only the request level ends sleep, never a timer
                if (!sleep_request)
                begin
                    state_nxt = ST_WAKE;
                    cnt_nxt   = `WAKE_CYCLES - 2'h1;
                end
            end
            ST_WAKE:
            begin
                if (cnt_r == 2'h1)
                begin
                    state_nxt = ST_AWAKE;
                    rec_nxt   = 2'(`RECOVERY_CYCLES);
                end
                cnt_nxt = cnt_r - 2'h1;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ST_AWAKE;
            cnt_r   <= 2'h0;
            rec_r   <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            rec_r   <= rec_nxt;
        end
    end

    // ----------------------------------------
    // gating
    // ----------------------------------------
    logic awake;
    assign awake = (state_r == ST_AWAKE);

    // memory array and burst state see no strobe outside awake, so they hold
    assign access_en = awake && cmd_access;
    // writes held off during recovery as a guard on top of controller duty
    // reads stay open during recovery; only writes wait for the counter
    assign write_en  = access_en && cmd_write && (rec_r == 2'h0);
    assign dq_oe_n   = !awake;

    assign status.asleep      = (state_r == ST_ASLEEP);
    assign status.recovering  = (state_r == ST_WAKE) || (rec_r != 2'h0);
    assign status.access_ok   = awake && (rec_r == 2'h0);
    assign status.outputs_off = !awake;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence req_rise_s;
        !$past(sleep_request) && sleep_request && awake;
    endsequence

    sequence req_fall_s;
        status.asleep && !sleep_request;
    endsequence

    sequence entry_s;
        !status.asleep ##1 status.asleep;
    endsequence

    sequence wake_s;
        !awake ##1 awake;
    endsequence

    entry_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
        req_rise_s |-> !status.asleep ##1 !status.asleep ##1 status.asleep)
        else $error("sleep not entered two cycles after request");

    wake_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
        req_fall_s |-> ##1 !awake ##1 awake)
        else $error("wake not two cycles after request fell");

    hold_sleep_a: assert property (@(posedge sys_clk) disable iff (rst)
        status.asleep && sleep_request |=> status.asleep)
        else $error("sleep ended while request high");

    no_access_a: assert property (@(posedge sys_clk) disable iff (rst)
        !awake |-> !access_en && !write_en)
        else $error("access while not awake");

    hiz_out_a: assert property (@(posedge sys_clk) disable iff (rst)
        status.asleep |-> dq_oe_n)
        else $error("data driven while asleep");

    entry_start_a: assert property (@(posedge sys_clk) disable iff (rst)
        awake && sleep_request |=> state_r == ST_ENTER)
        else $error("request did not start entry");

    state_frozen_a: assert property (@(posedge sys_clk) disable iff (rst)
        status.asleep && cmd_access |-> !access_en)
        else $error("state touched in sleep");

    no_write_rec_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(state_r == ST_WAKE) |-> !write_en)
        else $error("write during recovery");

    ready_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
        status.access_ok |-> awake && !status.recovering)
        else $error("access_ok during recovery");

    entry_steps_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state_r == ST_ENTER) |-> entry_s)
        else $error("entry phase not exactly one cycle");

    wake_steps_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state_r == ST_WAKE) |-> wake_s)
        else $error("wake phase not exactly one cycle");

    entry_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state_r == ST_ENTER) |-> $past(sleep_request))
        else $error("entry started without request");

    wake_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state_r == ST_WAKE) |-> !$past(sleep_request))
        else $error("sleep left while request high");

    cnt_enter_a: assert property (@(posedge sys_clk) disable iff (rst)
        state_r == ST_ENTER |-> cnt_r == `ENTRY_CYCLES - 2'h1)
        else $error("entry counter out of step");

    cnt_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
        state_r == ST_WAKE |-> cnt_r == `WAKE_CYCLES - 2'h1)
        else $error("wake counter out of step");

    counters_held_a: assert property (@(posedge sys_clk) disable iff (rst)
        status.asleep && sleep_request |=> $stable(cnt_r) && $stable(rec_r))
        else $error("sequencer counters moved in sleep");

    recover_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(state_r == ST_WAKE) |-> status.recovering ##1 !status.recovering)
        else $error("recovery not one cycle long");

    read_in_rec_a: assert property (@(posedge sys_clk) disable iff (rst)
        awake && status.recovering && cmd_access && !cmd_write |-> access_en)
        else $error("read refused during recovery");

    awake_serves_a: assert property (@(posedge sys_clk) disable iff (rst)
        awake && cmd_access |-> access_en)
        else $error("access dropped while awake");

    write_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
        status.access_ok && cmd_access && cmd_write |-> write_en)
        else $error("write refused after recovery");

    entry_hiz_a: assert property (@(posedge sys_clk) disable iff (rst)
        awake && sleep_request |=> dq_oe_n && status.outputs_off)
        else $error("outputs on after entry began");

endmodule // sram_sleep_mode_control
`default_nettype wire

// [dv/sleep_host.sv]
// Purpose: controller model on the far side of the sram sleep control
// Assumes: the bench calls its tasks at a falling edge
// Notes:   commands are forced idle around sleep so nothing is pending
`default_nettype none
module sleep_host (
    // clock
    input  wire logic sys_clk,
    // requests toward the sram
    output var logic  sleep_request,
    output var logic  cmd_access,
    output var logic  cmd_write
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sleep_request = 1'h0;
        cmd_access    = 1'h0;
        cmd_write     = 1'h0;
    end
    task automatic cmd(input logic acc, input logic wr);
        cmd_access = acc;
        cmd_write  = wr;
    endtask
    // deselect on every sleep edge; the bench counts entry and wake cycles
    task automatic sleep(input logic lvl);
        cmd_access    = 1'h0;
        cmd_write     = 1'h0;
        sleep_request = lvl;
    endtask
endmodule // sleep_host
`default_nettype wire

// [dv/sram_sleep_mode_control_bench.sv]
// Purpose: self-checking bench for the sram sleep control
// Assumes: one command per cycle, driven on the falling edge
// Notes:   outputs_off is compared against the expected data enable bit
`default_nettype none
module sram_sleep_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0;
    logic rst     = 1'h1;
    logic sleep_request, cmd_access, cmd_write, access_en, write_en, dq_oe_n;
    sleep_ctrl_pkg::sleep_status_t status;
    int   err_total   = 0;
    int   check_count = 0;
    always #10 sys_clk = ~sys_clk;
    sleep_host host_u (.sys_clk(sys_clk), .sleep_request(sleep_request),
        .cmd_access(cmd_access), .cmd_write(cmd_write));
    sram_sleep_mode_control dut_u (.sys_clk(sys_clk), .rst(rst),
        .sleep_request(sleep_request), .cmd_access(cmd_access), .cmd_write(cmd_write),
        .access_en(access_en), .write_en(write_en), .dq_oe_n(dq_oe_n), .status(status));
    // vector: access_en write_en dq_oe_n asleep recovering access_ok
    // outputs_off must follow the enable bit, so it is appended from exp[3]
    task automatic chk(input logic [5:0] exp);
        logic [6:0] got;
        got = {access_en, write_en, dq_oe_n, status.asleep, status.recovering,
               status.access_ok, status.outputs_off};
        check_count++;
        if (got !== {exp, exp[3]})
        begin
            err_total++;
            $display("CHECK FAILED outputs exp %h got %h", {exp, exp[3]}, got);
        end
    endtask
    task automatic nx();
        @(negedge sys_clk);
        #2;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // a long sleep with commands held active, then a write probe inside recovery
    task automatic t_sleep_wake();
        @(negedge sys_clk);
        host_u.cmd(1'h1, 1'h1);
        #2 chk(6'h31);
        @(negedge sys_clk);
        host_u.sleep(1'h1);
        #2 chk(6'h01);
        nx();
        chk(6'h08);
        @(negedge sys_clk);
        host_u.cmd(1'h1, 1'h1);
        #2 chk(6'h0C);
        repeat (6)
        begin
            nx();
            chk(6'h0C);
        end
        @(negedge sys_clk);
        host_u.sleep(1'h0);
        #2 chk(6'h0C);
        nx();
        chk(6'h0A);
        // off-contract write: the device must still hold it back while recovering
        @(negedge sys_clk);
        host_u.cmd(1'h1, 1'h1);
        #2 chk(6'h22);
        nx();
        chk(6'h31);
        $display("sleep and wake test done");
    endtask
    // request dropped during entry still reaches sleep, wakes, then a read in recovery
    task automatic t_short_pulse();
        @(negedge sys_clk);
        host_u.sleep(1'h1);
        #2 chk(6'h01);
        @(negedge sys_clk);
        host_u.sleep(1'h0);
        #2 chk(6'h08);
        nx();
        chk(6'h0C);
        nx();
        chk(6'h0A);
        @(negedge sys_clk);
        host_u.cmd(1'h1, 1'h0);
        #2 chk(6'h22);
        nx();
        chk(6'h21);
        $display("short pulse test done");
    endtask
    // request raised again during wake-up, then a reset taken while asleep
    task automatic t_rearm();
        @(negedge sys_clk);
        host_u.sleep(1'h1);
        #2 chk(6'h01);
        nx();
        chk(6'h08);
        nx();
        chk(6'h0C);
        @(negedge sys_clk);
        host_u.sleep(1'h0);
        #2 chk(6'h0C);
        @(negedge sys_clk);
        host_u.sleep(1'h1);
        #2 chk(6'h0A);
        nx();
        chk(6'h02);
        nx();
        chk(6'h08);
        nx();
        chk(6'h0C);
        @(negedge sys_clk);
        host_u.sleep(1'h0);
        rst = 1'h1;
        #2 chk(6'h01);
        @(negedge sys_clk);
        rst = 1'h0;
        #2 chk(6'h01);
        @(negedge sys_clk);
        host_u.cmd(1'h1, 1'h0);
        #2 chk(6'h21);
        $display("rearm and reset test done");
    endtask
    initial
    begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'h0;
        t_sleep_wake();
        t_short_pulse();
        t_rearm();
        finish_test();
    end
endmodule // sram_sleep_mode_control_bench
`default_nettype wire
